// File: src/mrps_host.sv
// Host end: sequences power-off, reset and PCIe reset pins of the modem
// Summary of operation
// - Reset low over 2 ms, 10 ms default
// - Module restarts after reset pin released
// - Pin reset keeps module power manager on
// - Pin reset procedure for upgrade and recovery
// - Power-cycle procedure for warm boot, restart
// - Reset at least 16 ms after PCIe reset
// - Power-off pin at least 2 ms after reset
// - Power-off held 500 ms to discharge
// - Reset released at least 8 ms after power-on
// - PCIe reset last, 50 ms after power-on
// - Clock request level frozen during L2
// - Host leaves clock request released in L2
// - L1.2 both high; L2 PCIe reset low
// - Requests map system states to sequences
// - Same mapping on other operating systems
// - Module link single lane, Gen2 or Gen1
// - Module powered while power-off pin high
// - PCIe reset resets module only in crash dump
`timescale 1ns/100ps
module mrps_host
    import mrps_pkg::*;
#(
    parameter int RST_PULSE_CYC = ms_to_cyc(T_RST_REC_MS),
    parameter int OFF1_CYC = ms_to_cyc(T_OFF1_REC_MS),
    parameter int OFF2_CYC = ms_to_cyc(T_OFF2_REC_MS),
    parameter int DISCHG_CYC = ms_to_cyc(T_OFF_MS),
    parameter int ON1_CYC = ms_to_cyc(T_ON1_REC_MS),
    parameter int ON2_CYC = ms_to_cyc(T_ON2_REC_MS)
) (
    input wire logic clk,
    input wire logic sys_rst,
    mrps_if.host pins,
    input wire logic req_start,
    input wire logic req_shutdown,
    input wire logic req_reset_pin,
    input wire logic req_reset_cycle,
    input wire logic req_l2_enter,
    input wire logic req_l2_exit,
    input wire logic req_clk_wake,
    output logic busy_r,
    output logic powered_r,
    output logic in_l2_r,
    output logic done_r,
    output logic refused_r,
    output logic clkreq_low_r
);
    // Load values for the down-counter; PCIe reset waits the rest of ON2
    localparam logic [CNT_W-1:0] LD_RST = CNT_W'(RST_PULSE_CYC);
    localparam logic [CNT_W-1:0] LD_OFF1 = CNT_W'(OFF1_CYC);
    localparam logic [CNT_W-1:0] LD_OFF2 = CNT_W'(OFF2_CYC);
    localparam logic [CNT_W-1:0] LD_DISCHG = CNT_W'(DISCHG_CYC);
    localparam logic [CNT_W-1:0] LD_ON1 = CNT_W'(ON1_CYC);
    localparam logic [CNT_W-1:0] LD_ON2 = CNT_W'(ON2_CYC - ON1_CYC);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_STEP = CNT_W'(1);

    mrps_hst_t state_r;
    mrps_hst_t state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic pin_seq_r;
    logic pin_seq_nxt;
    logic cycle_r;
    logic cycle_nxt;
    logic tmr_done;
    logic any_req;
    logic accept;
    logic fpo_r;
    logic rst_r;
    logic perst_r;
    logic [2:0] pin_nxt;

    // Pin levels {power-off_n, reset_n, perst_n} for each state
    function automatic logic [2:0] pins_of(input mrps_hst_t st);
        case (st)
            HS_PWRUP_RST: pins_of = {PIN_HIGH, PIN_LOW, PIN_LOW};
            HS_PWRUP_PERST: pins_of = {PIN_HIGH, PIN_HIGH, PIN_LOW};
            HS_ON: pins_of = {PIN_HIGH, PIN_HIGH, PIN_HIGH};
            HS_DN_RST: pins_of = {PIN_HIGH, PIN_HIGH, PIN_LOW};
            HS_DN_FPO: pins_of = {PIN_HIGH, PIN_LOW, PIN_LOW};
            HS_PRST_HOLD: pins_of = {PIN_HIGH, PIN_LOW, PIN_LOW};
            HS_PRST_REL: pins_of = {PIN_HIGH, PIN_HIGH, PIN_LOW};
            HS_L2: pins_of = {PIN_HIGH, PIN_HIGH, PIN_LOW};
            default: pins_of = {PIN_LOW, PIN_LOW, PIN_LOW};
        endcase
    endfunction

    assign tmr_done = (cnt_r == CNT_ZERO);
    assign any_req = req_start | req_shutdown | req_reset_pin | req_reset_cycle |
                     req_l2_enter | req_l2_exit;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = tmr_done ? CNT_ZERO : cnt_r - CNT_STEP;
        pin_seq_nxt = pin_seq_r;
        cycle_nxt = cycle_r;
        accept = 1'b0;
        case (state_r)
            HS_OFF: begin
                // Start-up only after the discharge hold has run out
                if (req_start) begin
                    state_nxt = HS_PWRUP_RST;
                    cnt_nxt = LD_ON1;
                    accept = 1'b1;
                end
            end
            HS_PWRUP_RST: begin
                if (tmr_done) begin
                    state_nxt = HS_PWRUP_PERST;
                    cnt_nxt = LD_ON2;
                end
            end
            HS_PWRUP_PERST: begin
                if (tmr_done) begin
                    state_nxt = HS_ON;
                end
            end
            HS_ON: begin
                if (req_shutdown) begin
                    state_nxt = HS_DN_RST;
                    cnt_nxt = LD_OFF1;
                    pin_seq_nxt = 1'b0;
                    cycle_nxt = 1'b0;
                    accept = 1'b1;
                end else if (req_reset_cycle) begin
                    state_nxt = HS_DN_RST;
                    cnt_nxt = LD_OFF1;
                    pin_seq_nxt = 1'b0;
                    cycle_nxt = 1'b1;
                    accept = 1'b1;
                end else if (req_reset_pin) begin
                    state_nxt = HS_DN_RST;
                    cnt_nxt = LD_OFF1;
                    pin_seq_nxt = 1'b1;
                    cycle_nxt = 1'b0;
                    accept = 1'b1;
                end else if (req_l2_enter) begin
                    state_nxt = HS_L2;
                    accept = 1'b1;
                end
            end
            HS_DN_RST: begin
                if (tmr_done) begin
                    state_nxt = pin_seq_r ? HS_PRST_HOLD : HS_DN_FPO;
                    cnt_nxt = pin_seq_r ? LD_RST : LD_OFF2;
                end
            end
            HS_DN_FPO: begin
                if (tmr_done) begin
                    state_nxt = HS_DISCHG;
                    cnt_nxt = LD_DISCHG;
                end
            end
            HS_DISCHG: begin
                // Power cycle goes straight on to start-up
                if (tmr_done) begin
                    state_nxt = cycle_r ? HS_PWRUP_RST : HS_OFF;
                    cnt_nxt = cycle_r ? LD_ON1 : CNT_ZERO;
                    cycle_nxt = 1'b0;
                end
            end
            HS_PRST_HOLD: begin
                if (tmr_done) begin
                    state_nxt = HS_PRST_REL;
                    cnt_nxt = LD_ON2;
                end
            end
            HS_PRST_REL: begin
                if (tmr_done) begin
                    state_nxt = HS_ON;
                    pin_seq_nxt = 1'b0;
                end
            end
            HS_L2: begin
                if (req_l2_exit) begin
                    state_nxt = HS_ON;
                    accept = 1'b1;
                end else if (req_shutdown) begin
                    state_nxt = HS_DN_RST;
                    cnt_nxt = LD_OFF1;
                    pin_seq_nxt = 1'b0;
                    cycle_nxt = 1'b0;
                    accept = 1'b1;
                end
            end
            default: begin
                state_nxt = HS_DISCHG;
                cnt_nxt = LD_DISCHG;
            end
        endcase
    end

    // Reset lands in the discharge hold: the module may have been powered
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= HS_DISCHG;
            cnt_r <= LD_DISCHG;
            pin_seq_r <= 1'b0;
            cycle_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            pin_seq_r <= pin_seq_nxt;
            cycle_r <= cycle_nxt;
        end
    end

    assign pin_nxt = pins_of(state_nxt);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fpo_r <= PIN_LOW;
            rst_r <= PIN_LOW;
            perst_r <= PIN_LOW;
        end else begin
            fpo_r <= pin_nxt[2];
            rst_r <= pin_nxt[1];
            perst_r <= pin_nxt[0];
        end
    end

    assign pins.full_power_off_n = fpo_r;
    assign pins.reset_n = rst_r;
    assign pins.perst_n = perst_r;
    assign pins.clkreq_host_o = PIN_LOW;

    // Wake request only in the active state; released in L2 to save standby current
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clkreq_low_r <= 1'b0;
        end else begin
            clkreq_low_r <= (state_nxt == HS_ON) & req_clk_wake;
        end
    end

    assign pins.clkreq_host_oe = clkreq_low_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busy_r <= 1'b1;
            powered_r <= 1'b0;
            in_l2_r <= 1'b0;
            done_r <= 1'b0;
            refused_r <= 1'b0;
        end else begin
            busy_r <= !(state_nxt inside {HS_OFF, HS_ON, HS_L2});
            powered_r <= (state_nxt == HS_ON) | (state_nxt == HS_L2);
            in_l2_r <= (state_nxt == HS_L2);
            done_r <= (state_nxt != state_r) &&
                      (state_nxt inside {HS_OFF, HS_ON, HS_L2}) && !accept;
            refused_r <= any_req & ~accept;
        end
    end
endmodule // mrps_host

// File: src/mrps_pkg.sv
// Shared timing constants and state codes for the modem reset and power sequencer
package mrps_pkg;
    // System clock rate, in kHz
    localparam int CLK_KHZ = 125_000;

    // Inter-pin delays in ms: least values and the defaults used
    localparam int T_RST_MIN_MS = 2;
    localparam int T_RST_REC_MS = 10;
    localparam int T_OFF1_MIN_MS = 16;
    localparam int T_OFF1_REC_MS = 20;
    localparam int T_OFF2_MIN_MS = 2;
    localparam int T_OFF2_REC_MS = 10;
    localparam int T_OFF_MS = 500;
    localparam int T_ON1_MIN_MS = 8;
    localparam int T_ON1_REC_MS = 20;
    localparam int T_ON2_MIN_MS = 50;
    localparam int T_ON2_REC_MS = 100;

    // Wide enough for the 500 ms discharge hold
    localparam int CNT_W = 27;

    // Pin levels
    localparam logic PIN_LOW = 1'b0;
    localparam logic PIN_HIGH = 1'b1;

    // Whole ms always give whole cycles, so no rounding is lost
    function automatic int ms_to_cyc(input int ms);
        return ms * CLK_KHZ;
    endfunction

    typedef enum logic [9:0] {
        HS_OFF = 10'h001,
        HS_PWRUP_RST = 10'h002,
        HS_PWRUP_PERST = 10'h004,
        HS_ON = 10'h008,
        HS_DN_RST = 10'h010,
        HS_DN_FPO = 10'h020,
        HS_DISCHG = 10'h040,
        HS_PRST_HOLD = 10'h080,
        HS_PRST_REL = 10'h100,
        HS_L2 = 10'h200
    } mrps_hst_t;
endpackage

// File: src/mrps_if.sv
// Sideband pins between the host sequencer and the modem module
`timescale 1ns/100ps
interface mrps_if;
    logic full_power_off_n;
    logic reset_n;
    logic perst_n;
    logic clkreq_host_o;
    logic clkreq_host_oe;
    logic clkreq_dev_o;
    logic clkreq_dev_oe;
    logic clkreq_n;

    // Open-drain line with pull-up: low while any side drives low
    assign clkreq_n = ~((clkreq_host_oe & ~clkreq_host_o) | (clkreq_dev_oe & ~clkreq_dev_o));

    modport host (
        output full_power_off_n,
        output reset_n,
        output perst_n,
        output clkreq_host_o,
        output clkreq_host_oe,
        input clkreq_n
    );

    modport dev (
        input full_power_off_n,
        input reset_n,
        input perst_n,
        output clkreq_dev_o,
        output clkreq_dev_oe,
        input clkreq_n
    );
endinterface

// File: src/mrps_dev.sv
// Modem end: reacts to power-off, reset and PCIe reset pins
`timescale 1ns/100ps
module mrps_dev
    import mrps_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    mrps_if.dev pins,
    input wire logic crash_dump,
    input wire logic dev_clk_req,
    input wire logic partner_gen2,
    output logic pmu_on_r,
    output logic core_rst_r,
    output logic pcie_rst_r,
    output logic restart_r,
    output logic link_l2_r,
    output logic link_gen2_r,
    output logic link_gen1_r,
    output logic clkreq_seen_r
);
    logic [1:0] fpo_sy_r;
    logic [1:0] rst_sy_r;
    logic [1:0] perst_sy_r;
    logic [1:0] clk_sy_r;
    logic fpo_s;
    logic rst_s;
    logic perst_s;
    logic core_rst_nxt;
    logic l2_nxt;
    logic clkreq_oe_r;

    // Pins come from another device: two flops before use
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fpo_sy_r <= 2'h0;
            rst_sy_r <= 2'h0;
            perst_sy_r <= 2'h0;
            clk_sy_r <= 2'h3;
        end else begin
            fpo_sy_r <= {fpo_sy_r[0], pins.full_power_off_n};
            rst_sy_r <= {rst_sy_r[0], pins.reset_n};
            perst_sy_r <= {perst_sy_r[0], pins.perst_n};
            clk_sy_r <= {clk_sy_r[0], pins.clkreq_n};
        end
    end

    assign fpo_s = fpo_sy_r[1];
    assign rst_s = rst_sy_r[1];
    assign perst_s = perst_sy_r[1];

    // Crash dump widens PCIe reset to the whole module
    assign core_rst_nxt = ~fpo_s | ~rst_s | (~perst_s & crash_dump);
    assign l2_nxt = fpo_s & rst_s & ~perst_s & ~crash_dump;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pmu_on_r <= 1'b0;
        end else begin
            // Power manager follows only the power-off pin; reset pin leaves it on
            pmu_on_r <= fpo_s;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            core_rst_r <= 1'b1;
            pcie_rst_r <= 1'b1;
            restart_r <= 1'b0;
        end else begin
            core_rst_r <= core_rst_nxt;
            pcie_rst_r <= core_rst_nxt | ~perst_s;
            // Release of reset restarts the core from its initial state
            restart_r <= core_rst_r & ~core_rst_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            link_l2_r <= 1'b0;
            clkreq_oe_r <= 1'b0;
        end else begin
            link_l2_r <= l2_nxt;
            // Level taken on L2 entry is frozen for the whole L2 stay
            if (!link_l2_r || !l2_nxt) begin
                clkreq_oe_r <= dev_clk_req & ~core_rst_nxt;
            end
        end
    end

    assign pins.clkreq_dev_o = PIN_LOW;
    assign pins.clkreq_dev_oe = clkreq_oe_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            link_gen2_r <= 1'b0;
            link_gen1_r <= 1'b0;
            clkreq_seen_r <= 1'b0;
        end else begin
            // Single lane, Gen2 when the partner can, else Gen1
            link_gen2_r <= ~(core_rst_nxt | ~perst_s) & partner_gen2;
            link_gen1_r <= ~(core_rst_nxt | ~perst_s) & ~partner_gen2;
            clkreq_seen_r <= ~clk_sy_r[1];
        end
    end
endmodule // mrps_dev

// File: dv/mrps_chk.sv
// Assertions on the sideband pins between the host and modem ends
`timescale 1ns/100ps
module mrps_chk #(
    parameter int RST_PULSE_CYC = 20,
    parameter int OFF1_CYC = 32,
    parameter int OFF2_CYC = 8,
    parameter int DISCHG_CYC = 100,
    parameter int ON1_CYC = 16,
    parameter int ON2_CYC = 100
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic full_power_off_n,
    input wire logic reset_n,
    input wire logic perst_n,
    input wire logic clkreq_host_oe,
    input wire logic clkreq_dev_oe,
    input wire logic clkreq_n
);
    int fpo_lo_r;
    int fpo_hi_r;
    int rst_lo_r;
    int perst_lo_r;
    logic in_l2;

    // Margin of 4 lets the modem's pin synchronisers catch up
    assign in_l2 = (perst_lo_r >= 4) && reset_n && full_power_off_n;

    // Level run lengths; spacings are minima, so compared with >=
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fpo_lo_r <= 0;
            fpo_hi_r <= 0;
            rst_lo_r <= 0;
            perst_lo_r <= 0;
        end else begin
            fpo_lo_r <= full_power_off_n ? 0 : fpo_lo_r + 1;
            fpo_hi_r <= full_power_off_n ? fpo_hi_r + 1 : 0;
            rst_lo_r <= reset_n ? 0 : rst_lo_r + 1;
            perst_lo_r <= perst_n ? 0 : perst_lo_r + 1;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    property p_rst_pulse;
        $rose(reset_n) |-> rst_lo_r >= RST_PULSE_CYC;
    endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too short");

    property p_rst_after_perst;
        $fell(reset_n) |-> !perst_n && perst_lo_r >= OFF1_CYC;
    endproperty
    a_rst_after_perst: assert property (p_rst_after_perst) else $error("reset too early");

    property p_fpo_after_rst;
        $fell(full_power_off_n) |-> !reset_n && rst_lo_r >= OFF2_CYC;
    endproperty
    a_fpo_after_rst: assert property (p_fpo_after_rst) else $error("power-off too early");

    property p_dischg;
        $rose(full_power_off_n) |-> fpo_lo_r >= DISCHG_CYC;
    endproperty
    a_dischg: assert property (p_dischg) else $error("discharge hold too short");

    property p_on1;
        $rose(reset_n) |-> full_power_off_n && fpo_hi_r >= ON1_CYC;
    endproperty
    a_on1: assert property (p_on1) else $error("reset released too early");

    property p_perst_last;
        $rose(perst_n) |-> reset_n && full_power_off_n && fpo_hi_r >= ON2_CYC;
    endproperty
    a_perst_last: assert property (p_perst_last) else $error("PCIe reset not last");

    property p_l2_frozen;
        in_l2 |=> !in_l2 || ($stable(clkreq_n) && $stable(clkreq_dev_oe));
    endproperty
    a_l2_frozen: assert property (p_l2_frozen) else $error("clock request moved in L2");

    property p_l2_host_off;
        in_l2 |-> !clkreq_host_oe;
    endproperty
    a_l2_host_off: assert property (p_l2_host_off) else $error("host drives clock request");

    c_dischg: cover property ($rose(full_power_off_n));
    c_perst: cover property ($rose(perst_n) && full_power_off_n);
    c_l2: cover property (in_l2);
endmodule // mrps_chk

// File: dv/testbench.sv
// Self-checking bench joining the host and modem ends over the sideband pins
`timescale 1ns/100ps
module testbench;
    localparam int RST_PULSE_CYC = 20;
    localparam int OFF1_CYC = 32;
    localparam int OFF2_CYC = 8;
    localparam int DISCHG_CYC = 100;
    localparam int ON1_CYC = 16;
    localparam int ON2_CYC = 100;

    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [5:0] req_v = 6'h00;
    logic wake = 1'b0;
    logic crash = 1'b0;
    logic dev_req = 1'b0;
    logic gen2 = 1'b1;
    logic busy_r, powered_r, in_l2_r, refused_r, clkreq_low_r, done_r;
    logic pmu_on_r, core_rst_r, pcie_rst_r, restart_r, link_l2_r;
    logic link_gen2_r, link_gen1_r, clkreq_seen_r;
    int n_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    int n_ref = 0;
    int n_restart = 0;
    int n_done = 0;
    int t_r[3];
    int t_f[3];
    logic [2:0] pin_q = 3'h0;
    logic gap = 1'b0;
    logic [2:0] pins;

    mrps_if u_mrps_if();
    assign pins = {u_mrps_if.full_power_off_n, u_mrps_if.reset_n, u_mrps_if.perst_n};

    mrps_host #(.RST_PULSE_CYC(RST_PULSE_CYC), .OFF1_CYC(OFF1_CYC), .OFF2_CYC(OFF2_CYC),
        .DISCHG_CYC(DISCHG_CYC), .ON1_CYC(ON1_CYC), .ON2_CYC(ON2_CYC)) u_mrps_host (
        .clk(clk), .sys_rst(sys_rst), .pins(u_mrps_if), .req_start(req_v[0]),
        .req_shutdown(req_v[1]), .req_reset_pin(req_v[2]), .req_reset_cycle(req_v[3]),
        .req_l2_enter(req_v[4]), .req_l2_exit(req_v[5]), .req_clk_wake(wake),
        .busy_r(busy_r), .powered_r(powered_r), .in_l2_r(in_l2_r), .done_r(done_r),
        .refused_r(refused_r), .clkreq_low_r(clkreq_low_r));

    mrps_dev u_mrps_dev (.clk(clk), .sys_rst(sys_rst), .pins(u_mrps_if), .crash_dump(crash),
        .dev_clk_req(dev_req), .partner_gen2(gen2), .pmu_on_r(pmu_on_r),
        .core_rst_r(core_rst_r), .pcie_rst_r(pcie_rst_r), .restart_r(restart_r),
        .link_l2_r(link_l2_r), .link_gen2_r(link_gen2_r), .link_gen1_r(link_gen1_r),
        .clkreq_seen_r(clkreq_seen_r));

    mrps_chk #(.RST_PULSE_CYC(RST_PULSE_CYC), .OFF1_CYC(OFF1_CYC), .OFF2_CYC(OFF2_CYC),
        .DISCHG_CYC(DISCHG_CYC), .ON1_CYC(ON1_CYC), .ON2_CYC(ON2_CYC)) u_mrps_chk (
        .clk(clk), .sys_rst(sys_rst), .full_power_off_n(u_mrps_if.full_power_off_n),
        .reset_n(u_mrps_if.reset_n), .perst_n(u_mrps_if.perst_n),
        .clkreq_host_oe(u_mrps_if.clkreq_host_oe), .clkreq_dev_oe(u_mrps_if.clkreq_dev_oe),
        .clkreq_n(u_mrps_if.clkreq_n));

    always #4 clk = ~clk;

    // Pin edge times in cycles, so spacings are judged from the wire itself
    always @(posedge clk) begin
        cyc <= cyc + 1;
        pin_q <= pins;
        for (int i = 0; i < 3; i++) begin
            if (pins[i] && !pin_q[i]) t_r[i] <= cyc;
            if (!pins[i] && pin_q[i]) t_f[i] <= cyc;
        end
        if (refused_r) n_ref <= n_ref + 1;
        if (restart_r) n_restart <= n_restart + 1;
        if (done_r) n_done <= n_done + 1;
        if (!pmu_on_r || !pins[2]) gap <= 1'b1;
    end

    task automatic end_sim();
        if (n_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic pulse(input int b);
        @(posedge clk);
        req_v[b] <= 1'b1;
        @(posedge clk);
        req_v[b] <= 1'b0;
    endtask

    // Bounded wait for the host to finish a timed sequence
    task automatic wait_idle();
        int i;
        i = 0;
        tick(1);
        while (busy_r !== 1'b0 && i < 2000) begin
            tick(1);
            i++;
        end
        chk(busy_r, 1'b0);
    endtask

    task automatic t_boot();
        wait_idle();
        chk({pins, powered_r, pmu_on_r}, 5'h00);
        pulse(1);
        tick(3);
        chk(n_ref, 1);
        chk(n_done, 1);
    endtask

    task automatic t_start();
        pulse(0);
        wait_idle();
        tick(3);
        chk(t_r[1] - t_r[2], ON1_CYC + 1);
        chk(t_r[0] - t_r[2], ON2_CYC + 2);
        chk({powered_r, pmu_on_r}, 2'h3);
        chk({pcie_rst_r, link_gen2_r, link_gen1_r}, 3'h2);
        @(posedge clk);
        gen2 <= 1'b0;
        wake <= 1'b1;
        tick(5);
        chk({link_gen2_r, link_gen1_r}, 2'h1);
        chk({u_mrps_if.clkreq_n, clkreq_low_r, clkreq_seen_r}, 3'h3);
        @(posedge clk);
        gen2 <= 1'b1;
        wake <= 1'b0;
        tick(5);
        chk(u_mrps_if.clkreq_n, 1'b1);
    endtask

    task automatic t_pin_reset();
        gap = 1'b0;
        n_restart = 0;
        pulse(2);
        wait_idle();
        tick(4);
        chk(t_f[1] - t_f[0], OFF1_CYC + 1);
        chk(t_r[1] - t_f[1], RST_PULSE_CYC + 1);
        chk(t_r[0] - t_r[1], ON2_CYC - ON1_CYC + 1);
        chk(gap, 1'b0);
        chk({n_restart[1:0], core_rst_r}, 3'h2);
    endtask

    task automatic t_l2();
        pulse(4);
        tick(5);
        chk({in_l2_r, u_mrps_if.perst_n, u_mrps_if.clkreq_host_oe}, 3'h4);
        chk({link_l2_r, pcie_rst_r, core_rst_r}, 3'h6);
        @(posedge clk);
        dev_req <= 1'b1;
        wake <= 1'b1;
        pulse(0);
        tick(5);
        chk(u_mrps_if.clkreq_n, 1'b1);
        chk(clkreq_low_r, 1'b0);
        chk(n_ref, 2);
        @(posedge clk);
        dev_req <= 1'b0;
        wake <= 1'b0;
        pulse(5);
        tick(5);
        chk({in_l2_r, u_mrps_if.perst_n, u_mrps_if.clkreq_n}, 3'h3);
    endtask

    task automatic t_crash();
        @(posedge clk);
        crash <= 1'b1;
        pulse(4);
        tick(5);
        chk({link_l2_r, core_rst_r}, 2'h1);
        pulse(5);
        @(posedge clk);
        crash <= 1'b0;
        tick(5);
        chk(core_rst_r, 1'b0);
    endtask

    task automatic t_cycle();
        gap = 1'b0;
        pulse(3);
        wait_idle();
        tick(3);
        chk(t_f[2] - t_f[1], OFF2_CYC + 1);
        chk(t_r[2] - t_f[2] >= DISCHG_CYC, 1'b1);
        chk({gap, powered_r, pmu_on_r}, 3'h7);
    endtask

    // Shutdown taken from L2, where PCIe reset is already low
    task automatic t_shutdown();
        pulse(4);
        tick(2);
        pulse(1);
        wait_idle();
        tick(3);
        chk(t_f[1] - t_f[0], OFF1_CYC + 5);
        chk({pins, powered_r, pmu_on_r}, 5'h00);
        chk(n_done, 5);
    endtask

    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        t_boot();
        t_start();
        t_pin_reset();
        t_l2();
        t_crash();
        t_cycle();
        t_shutdown();
        end_sim();
    end

    // Whole run needs about 820 cycles
    initial begin
        #100000;
        n_errors++;
        $display("ERROR %0t: timeout", $time);
        end_sim();
    end
endmodule // testbench
